// >>> clock_prescaler_defines.vh
`ifndef CLOCK_PRESCALER_DEFINES_VH
`define CLOCK_PRESCALER_DEFINES_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_IDX_DIVIDE_CTRL   8'h61
`define REG_ADDR_DIVIDE_CTRL  12'h184
`define REG_ADDR_TRIM         12'h188
`define ADDR_WIDTH            12

// ----------------------------------------------------------------
// Divide control fields
// ----------------------------------------------------------------
`define UNLOCK_BIT            7
`define CODE_MSB              3
`define CODE_LSB              0
`define CODE_MAX              4'h8
`define CODE_RESET_PLAIN      4'h0
`define CODE_RESET_DIV8       4'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UNLOCK_WINDOW_CYCLES  3'h4

// ----------------------------------------------------------------
// Trim fields
// ----------------------------------------------------------------
`define TRIM_RANGE_BIT        7
`define TRIM_FACTORY_DEFAULT  8'h80

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// >>> divide_unlock_timer.v
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Unlock window: set on arm, cleared after fixed count or on consume
// ----------------------------------------------------------------
module divide_unlock_timer #(
  parameter [2:0] WINDOW = 3'h4
) (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Control
  input  wire       arm,
  input  wire       consume,
  // Status
  output reg        open_reg
);

  reg  [2:0] count_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      open_reg  <= 1'b0;
      count_reg <= 3'h0;
    end else if (open_reg) begin
      // Re-arming neither restarts nor clears the window
      if (consume || count_reg == WINDOW - 3'h1) begin
        open_reg  <= 1'b0;
        count_reg <= 3'h0;
      end else begin
        count_reg <= count_reg + 3'h1;
      end
    end else if (arm) begin
      open_reg  <= 1'b1;
      count_reg <= 3'h0;
    end
  end

endmodule

// >>> ripple_divider.v
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Glitch-free power-of-two divider, switches only at old period end
// ----------------------------------------------------------------
module ripple_divider #(
  parameter STAGES = 8
) (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Selection
  input  wire [3:0] code,
  input  wire [3:0] reset_code,
  // Divided clock
  output reg        div_clk_reg,
  output reg  [3:0] active_code_reg
);

  reg  [STAGES-1:0] count_reg;
  reg  [STAGES-1:0] half_mask;
  wire              period_end;
  wire              half_end;

  always @* begin
    half_mask = {STAGES{1'b0}};
    if (active_code_reg != 4'h0)
      half_mask = ({{(STAGES-1){1'b0}}, 1'b1} << (active_code_reg - 4'h1)) - 1'b1;
  end

  // Full mask = two halves; count wraps at end of each half period
  assign half_end   = (count_reg == half_mask);
  assign period_end = half_end && div_clk_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      count_reg       <= {STAGES{1'b0}};
      div_clk_reg     <= 1'b0;
      // Start at the fuse factor
      active_code_reg <= reset_code;
    end else if (active_code_reg == 4'h0 || code == 4'h0 && period_end) begin
      // Undivided: toggle each edge as a two-phase stand-in
      div_clk_reg     <= ~div_clk_reg;
      count_reg       <= {STAGES{1'b0}};
      if (div_clk_reg)
        active_code_reg <= code;
    end else if (half_end) begin
      div_clk_reg <= ~div_clk_reg;
      count_reg   <= {STAGES{1'b0}};
      // New factor only at an old period boundary
      if (div_clk_reg)
        active_code_reg <= code;
    end else begin
      count_reg <= count_reg + {{(STAGES-1){1'b0}}, 1'b1};
    end
  end

endmodule

// >>> system_clock_prescaler.v
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "clock_prescaler_defines.vh"

module system_clock_prescaler #(
  parameter [7:0] FACTORY_TRIM = `TRIM_FACTORY_DEFAULT,
  parameter       STAGES       = 8
) (
  // Clock and reset
  input  wire                    aclk,
  input  wire                    aresetn,
  // Fuse
  input  wire                    divide_by_eight_fuse,
  // AXI4-Lite write address
  input  wire [`ADDR_WIDTH-1:0]  s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  // AXI4-Lite read address
  input  wire [`ADDR_WIDTH-1:0]  s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  // Divided clock domains
  output reg                     processor_clock,
  output reg                     program_memory_clock,
  output reg                     peripheral_io_clock,
  output reg                     converter_clock,
  // Oscillator trim
  output reg  [7:0]              rc_oscillator_trim,
  output reg                     trim_range_select
);

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  reg  [`ADDR_WIDTH-1:0] awaddr_reg;
  reg                    aw_held_reg;
  reg  [7:0]             wdata_reg;
  reg                    wstrb0_reg;
  reg                    w_held_reg;
  reg  [3:0]             divide_select_code_reg;
  reg  [7:0]             trim_reg;
  reg                    fuse_seen_reg;
  reg  [31:0]            rdata_next;
  reg  [1:0]             rresp_next;
  wire                   divide_change_unlock;
  wire                   do_write;
  wire                   write_done;
  wire                   read_done;
  wire                   hit_ctrl;
  wire                   hit_trim;
  wire                   rd_hit_ctrl;
  wire                   rd_hit_trim;
  wire                   arm_unlock;
  wire                   code_write;
  wire                   trim_write;
  wire                   code_legal;
  wire [3:0]             new_code;
  wire                   div_clk;
  wire [3:0]             reset_code;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam [`ADDR_WIDTH-1:0] CTRL_ADDR   = `REG_ADDR_DIVIDE_CTRL;
  localparam [`ADDR_WIDTH-1:0] TRIM_ADDR   = `REG_ADDR_TRIM;
  localparam [7:0]             UNLOCK_ONLY = 8'h01 << `UNLOCK_BIT;

  // Word compare only; address bits below 2 ignored
  assign hit_ctrl    = (awaddr_reg[`ADDR_WIDTH-1:2] == CTRL_ADDR[`ADDR_WIDTH-1:2]);
  assign hit_trim    = (awaddr_reg[`ADDR_WIDTH-1:2] == TRIM_ADDR[`ADDR_WIDTH-1:2]);
  assign rd_hit_ctrl = (s_axi_araddr[`ADDR_WIDTH-1:2] == CTRL_ADDR[`ADDR_WIDTH-1:2]);
  assign rd_hit_trim = (s_axi_araddr[`ADDR_WIDTH-1:2] == TRIM_ADDR[`ADDR_WIDTH-1:2]);

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  assign do_write    = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign write_done  = s_axi_bvalid && s_axi_bready;
  assign read_done   = s_axi_rvalid && s_axi_rready;
  assign new_code    = wdata_reg[`CODE_MSB:`CODE_LSB];
  assign code_legal  = (new_code <= `CODE_MAX);
  // Unlock sets only with every other bit of wdata_reg (data bits 7:0) zero; bits 31:8 are not checked
  assign arm_unlock  = do_write && hit_ctrl && wstrb0_reg && wdata_reg == UNLOCK_ONLY;
  // Code write with unlock bit zero during the open window
  assign code_write  = do_write && hit_ctrl && wstrb0_reg &&
                       !wdata_reg[`UNLOCK_BIT] && divide_change_unlock;
  // Trim writes wait until the factory value is in
  assign trim_write  = fuse_seen_reg && do_write && hit_trim && wstrb0_reg;
  assign reset_code  = divide_by_eight_fuse ? `CODE_RESET_DIV8 : `CODE_RESET_PLAIN;

  // ----------------------------------------------------------------
  // Write address channel
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_held_reg   <= 1'b0;
      awaddr_reg    <= {`ADDR_WIDTH{1'b0}};
    end else if (s_axi_awvalid && s_axi_awready) begin
      awaddr_reg    <= s_axi_awaddr;
      aw_held_reg   <= 1'b1;
      s_axi_awready <= 1'b0;
    end else if (write_done) begin
      aw_held_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write data channel
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_held_reg   <= 1'b0;
      wdata_reg    <= 8'h00;
      wstrb0_reg   <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wdata_reg    <= s_axi_wdata[7:0];
      wstrb0_reg   <= s_axi_wstrb[0];
      w_held_reg   <= 1'b1;
      s_axi_wready <= 1'b0;
    end else if (write_done) begin
      w_held_reg   <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (hit_ctrl || hit_trim) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (write_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Unlock window
  // ----------------------------------------------------------------
  divide_unlock_timer #(
    .WINDOW   (`UNLOCK_WINDOW_CYCLES)
  ) u_unlock (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .arm      (arm_unlock),
    .consume  (code_write),
    .open_reg (divide_change_unlock)
  );

  // ----------------------------------------------------------------
  // Divide code and trim
  // ----------------------------------------------------------------
  // Fuse and factory value caught at first edge after release
  always @(posedge aclk) begin
    if (!aresetn)
      fuse_seen_reg <= 1'b0;
    else
      fuse_seen_reg <= 1'b1;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      divide_select_code_reg <= `CODE_RESET_PLAIN;
    end else if (!fuse_seen_reg) begin
      divide_select_code_reg <= reset_code;
    end else if (code_write && code_legal) begin
      // Reserved codes dropped
      divide_select_code_reg <= new_code;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator trim register
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      trim_reg <= 8'h00;
    end else if (!fuse_seen_reg) begin
      trim_reg <= FACTORY_TRIM;
    end else if (trim_write) begin
      trim_reg <= wdata_reg;
    end
  end

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  ripple_divider #(
    .STAGES          (STAGES)
  ) u_divider (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .code            (divide_select_code_reg),
    .reset_code      (reset_code),
    .div_clk_reg     (div_clk),
    .active_code_reg ()
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      processor_clock      <= 1'b0;
      program_memory_clock <= 1'b0;
      peripheral_io_clock  <= 1'b0;
      converter_clock      <= 1'b0;
    end else begin
      processor_clock      <= div_clk;
      program_memory_clock <= div_clk;
      peripheral_io_clock  <= div_clk;
      converter_clock      <= div_clk;
    end
  end

  // ----------------------------------------------------------------
  // Trim outputs
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      rc_oscillator_trim <= 8'h00;
      trim_range_select  <= 1'b0;
    end else begin
      rc_oscillator_trim <= trim_reg;
      trim_range_select  <= trim_reg[`TRIM_RANGE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = 32'h00000000;
    rresp_next = `RESP_OKAY;
    if (rd_hit_ctrl)
      rdata_next = {24'h000000, divide_change_unlock, 3'h0, divide_select_code_reg};
    else if (rd_hit_trim)
      rdata_next = {24'h000000, trim_reg};
    else
      rresp_next = `RESP_SLVERR;
  end

  // ----------------------------------------------------------------
  // Read response
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdata_next;
      s_axi_rresp   <= rresp_next;
    end else if (read_done) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// >>> prescaler_props.sv
`timescale 1ns/100ps
`include "clock_prescaler_defines.vh"
module prescaler_props (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Register bus
  input logic [11:0] s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [11:0] s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // Clocks and trim
  input logic        processor_clock,
  input logic        program_memory_clock,
  input logic        peripheral_io_clock,
  input logic        converter_clock,
  input logic [7:0]  rc_oscillator_trim,
  input logic        trim_range_select
);
  logic [11:0] wa_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  function automatic logic mapped(input logic [11:0] a);
    return a == `REG_ADDR_DIVIDE_CTRL || a == `REG_ADDR_TRIM;
  endfunction
  always @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready)
      wa_reg <= s_axi_awaddr;
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_domains_equal: assert property (processor_clock == program_memory_clock
    && processor_clock == peripheral_io_clock && processor_clock == converter_clock)
    else $error("clock domains differ");
  a_range_bit: assert property (trim_range_select == rc_oscillator_trim[7])
    else $error("range select differs from trim bit 7");
  a_clock_runs: assert property (1 |-> ##[1:800] $rose(processor_clock))
    else $error("divided clock stalled");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_unmapped: assert property (s_ar_take and !mapped(s_axi_araddr) |=> s_axi_rvalid
    && s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  a_read_mapped: assert property (s_ar_take and mapped(s_axi_araddr) |=> s_axi_rvalid
    && s_axi_rresp == `RESP_OKAY && s_axi_rdata[31:8] == 24'h0) else $error("bad read");
  a_write_resp: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (mapped(wa_reg) ? `RESP_OKAY : `RESP_SLVERR)) else $error("bad bresp");
  a_write_answer: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready
    ##[0:1] s_axi_bvalid) else $error("write not answered");
endmodule
bind system_clock_prescaler prescaler_props prescaler_props_inst (.*);

// >>> system_clock_prescaler_tb.sv
`timescale 1ns/100ps
`include "clock_prescaler_defines.vh"
module system_clock_prescaler_tb;
  localparam logic [7:0] TRIM0 = 8'h5A;
  localparam logic [11:0] CT = `REG_ADDR_DIVIDE_CTRL;
  localparam logic [11:0] TR = `REG_ADDR_TRIM;
  logic aclk, aresetn, divide_by_eight_fuse;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, p;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic processor_clock, program_memory_clock, peripheral_io_clock, converter_clock;
  logic trim_range_select;
  logic [7:0] rc_oscillator_trim;
  int n_errors, checked, cyc;
  system_clock_prescaler #(.FACTORY_TRIM(TRIM0)) system_clock_prescaler_inst (.*);
  always #10 aclk = ~aclk;
  // ----------------------------------------------------------------
  // Checks, bus tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Period of the divided clock in aclk cycles, after settling
  task automatic period(output logic [31:0] n);
    realtime t0;
    repeat (3) @(posedge processor_clock);
    t0 = $realtime;
    @(posedge processor_clock);
    n = 32'(int'(($realtime - t0) / 20.0));
    @(posedge aclk);
  endtask
  task automatic do_reset(input logic fuse);
    divide_by_eight_fuse <= fuse;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      stop_test;
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cyc} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {divide_by_eight_fuse, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
    do_reset(1'b1);
    rd(CT, 32'h3, `RESP_OKAY);
    rd(TR, {24'h0, TRIM0}, `RESP_OKAY);
    period(p);
    chk("period_div8", p, 32'h8);
    for (int i = 0; i < 2; i++) begin
      wr(TR, 8'h7F + 8'(i), `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("trim", {24'h0, rc_oscillator_trim}, 32'h7F + i);
      chk("range", {31'h0, trim_range_select}, 32'(i));
      rd(TR, 32'h7F + i, `RESP_OKAY);
    end
    wr(CT, 8'h05, `RESP_OKAY);
    rd(CT, 32'h3, `RESP_OKAY);
    wr(CT, 8'h85, `RESP_OKAY);
    wr(CT, 8'h05, `RESP_OKAY);
    rd(CT, 32'h3, `RESP_OKAY);
    wr(CT, 8'h80, `RESP_OKAY);
    repeat (8) @(posedge aclk);
    wr(CT, 8'h05, `RESP_OKAY);
    rd(CT, 32'h3, `RESP_OKAY);
    wr(CT, 8'h80, `RESP_OKAY);
    wr(CT, 8'h08, `RESP_OKAY);
    wr(CT, 8'h02, `RESP_OKAY);
    rd(CT, 32'h8, `RESP_OKAY);
    period(p);
    chk("period_div256", p, 32'h100);
    wr(CT, 8'h80, `RESP_OKAY);
    wr(CT, 8'h09, `RESP_OKAY);
    rd(CT, 32'h8, `RESP_OKAY);
    wr(CT, 8'h80, `RESP_OKAY);
    wr(CT, 8'h80, `RESP_OKAY);
    wr(CT, 8'h01, `RESP_OKAY);
    rd(CT, 32'h8, `RESP_OKAY);
    wr(12'h100, 8'h11, `RESP_SLVERR);
    rd(12'h100, 32'h0, `RESP_SLVERR);
    do_reset(1'b0);
    rd(CT, 32'h0, `RESP_OKAY);
    rd(TR, {24'h0, TRIM0}, `RESP_OKAY);
    period(p);
    chk("period_code0", p, 32'h2);
    wr(CT, 8'h80, `RESP_OKAY);
    wr(CT, 8'h03, `RESP_OKAY);
    rd(CT, 32'h3, `RESP_OKAY);
    stop_test;
  end
endmodule
